/* File: hw/nasi_top.sv */
`timescale 1ns/1ps
`include "nasi_defines.svh"
module nasi_top #(
    parameter int unsigned FLASH_ON_CYC = `NASI_CLK_KHZ * `NASI_FLASH_ON_MS,
    parameter int unsigned FLASH_GAP_CYC = `NASI_CLK_KHZ * `NASI_FLASH_GAP_MS,
    parameter int unsigned BLINK_HALF_CYC = `NASI_CLK_KHZ * `NASI_BLINK_HALF_MS,
    parameter int unsigned ACT_HALF_CYC = `NASI_CLK_KHZ * `NASI_ACT_HALF_MS,
    parameter int PORTS = 2
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // network conditions
    input wire logic link_err_i,
    input wire logic cyc_timeout_i,
    input wire logic host_online_i,
    input wire logic host_run_i,
    input wire logic net_init_fail_i,
    input wire logic sio_init_fail_i,
    // option fitting
    input wire logic opt_id_bad_i,
    input wire logic opt_mix_bad_i,
    input wire logic opt_unknown_i,
    // safety and motion
    input wire logic stop_active_i,
    input wire logic motion_req_i,
    input wire logic motion_busy_i,
    input wire logic estop_open_i,
    input wire logic host_estop_ok_i,
    input wire logic host_stop_ok_i,
    // module state
    input wire logic setup_state_i,
    input wire logic net_init_state_i,
    input wire logic exception_i,
    input wire logic diag_event_i,
    input wire logic identify_req_i,
    input wire logic id_mismatch_i,
    input wire logic no_ip_i,
    input wire logic no_name_i,
    input wire logic internal_fault_i,
    // ports
    input wire logic [PORTS-1:0] port_link_i,
    input wire logic [PORTS-1:0] port_act_i,
    // alarm and robot gate
    output logic alarm_active_o,
    output logic [15:0] alarm_group_o,
    output logic [15:0] alarm_type_o,
    output logic robot_enable_o,
    // lamps
    output logic network_state_lamp_o,
    output logic module_state_lamp_green_o,
    output logic module_state_lamp_red_o,
    output logic [PORTS-1:0] port_lamp_o
);
    import nasi_pkg::*;

    localparam int NIN = 24;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] syn;
    logic [PORTS-1:0] link_s, act_s;

    assign raw_in = {link_err_i, cyc_timeout_i, host_online_i, host_run_i,
        net_init_fail_i, sio_init_fail_i, opt_id_bad_i, opt_mix_bad_i,
        opt_unknown_i, stop_active_i, motion_req_i, motion_busy_i,
        estop_open_i, host_estop_ok_i, host_stop_ok_i, setup_state_i,
        net_init_state_i, exception_i, diag_event_i, identify_req_i,
        id_mismatch_i, no_ip_i, no_name_i, internal_fault_i};

    nasi_sync #(.W(NIN)) u_sync_cond (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .d_i(raw_in),
        .q_o(syn)
    );

    nasi_sync #(.W(2 * PORTS)) u_sync_port (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .d_i({port_link_i, port_act_i}),
        .q_o({link_s, act_s})
    );

    wire s_link_err = syn[23];
    wire s_timeout = syn[22];
    wire s_online = syn[21];
    wire s_run = syn[20];
    wire s_netfail = syn[19];
    wire s_siofail = syn[18];
    wire s_id_bad = syn[17];
    wire s_mix_bad = syn[16];
    wire s_unknown = syn[15];
    wire s_stop = syn[14];
    wire s_mreq = syn[13];
    wire s_mbusy = syn[12];
    wire s_estop = syn[11];
    wire s_h_estop = syn[10];
    wire s_h_stop = syn[9];
    wire s_setup = syn[8];
    wire s_netinit = syn[7];
    wire s_except = syn[6];
    wire s_diag = syn[5];
    wire s_ident = syn[4];
    wire s_idmis = syn[3];
    wire s_noip = syn[2];
    wire s_noname = syn[1];
    wire s_intfault = syn[0];

    ////////////////////////////////////////////////////////////////////////////
    // registers and apb decode

    logic [31:0] ctrl_reg;
    logic [`NASI_ALM_W-1:0] alarm_reg, alarm_next;
    logic stop_last_reg;
    logic [31:0] lamp_word;
    logic [31:0] cond_word;
    logic [31:0] rd_mux;
    logic [`NASI_ALM_W-1:0] alarm_set;

    wire unit_en = ctrl_reg[`NASI_CTRL_EN_BIT];
    wire acc_first = psel & penable & ~pready;
    wire acc_done = psel & penable & pready;
    wire sel_ctrl = (paddr == `NASI_OFF_CTRL);
    wire sel_alarm = (paddr == `NASI_OFF_ALARM);
    wire sel_code = (paddr == `NASI_OFF_CODE);
    wire sel_lamp = (paddr == `NASI_OFF_LAMP);
    wire sel_cond = (paddr == `NASI_OFF_COND);
    wire hit = sel_ctrl | sel_alarm | sel_code | sel_lamp | sel_cond;
    wire wr_ctrl = acc_done & pwrite & sel_ctrl;
    wire wr_alarm = acc_done & pwrite & sel_alarm;

    assign rd_mux = sel_ctrl ? ctrl_reg :
        sel_alarm ? {25'h0, alarm_reg} :
        sel_code ? {alarm_group_o, alarm_type_o} :
        sel_lamp ? lamp_word :
        sel_cond ? cond_word : 32'h0;

    assign cond_word = {8'h0, syn};

    ////////////////////////////////////////////////////////////////////////////
    // alarm sources

    // stop edge only counts while an axis or program is already moving
    wire stop_rise = s_stop & ~stop_last_reg;
    wire opt_bad = s_id_bad | s_mix_bad | s_unknown;

    always_comb begin
        alarm_set = '0;
        alarm_set[`NASI_ALM_LINK] = unit_en & s_link_err;
        alarm_set[`NASI_ALM_TIMEOUT] = unit_en & s_timeout;
        alarm_set[`NASI_ALM_STOP] = (s_stop & s_mreq) | (stop_rise & s_mbusy);
        alarm_set[`NASI_ALM_ESTOP] = s_estop;
        alarm_set[`NASI_ALM_NETINIT] = unit_en & s_netfail;
        alarm_set[`NASI_ALM_OPTSET] = opt_bad;
        alarm_set[`NASI_ALM_SIOINIT] = s_siofail;
    end

    // write one to clear; a source still present sets the bit again at once
    assign alarm_next = (alarm_reg & ~(wr_alarm ? pwdata[`NASI_ALM_W-1:0] : '0))
        | alarm_set;

    // worst alarm first: fitting, board init, safety, then link
    wire [15:0] type_sel =
        alarm_reg[`NASI_ALM_OPTSET] ? `NASI_TYPE_OPTSET :
        alarm_reg[`NASI_ALM_NETINIT] ? `NASI_TYPE_NETINIT :
        alarm_reg[`NASI_ALM_SIOINIT] ? `NASI_TYPE_SIOINIT :
        alarm_reg[`NASI_ALM_ESTOP] ? `NASI_TYPE_ESTOP :
        alarm_reg[`NASI_ALM_STOP] ? `NASI_TYPE_STOP :
        alarm_reg[`NASI_ALM_LINK] ? `NASI_TYPE_LINK :
        alarm_reg[`NASI_ALM_TIMEOUT] ? `NASI_TYPE_TIMEOUT : 16'h0;
    wire any_alarm = |alarm_reg;

    // host must actively supply both inputs while enabled; a disabled unit leaves the robot gate open
    wire run_ok = ~unit_en | (s_h_estop & s_h_stop);

    ////////////////////////////////////////////////////////////////////////////
    // blink timebases

    logic [31:0] blink_cnt_reg;
    logic blink_reg;
    logic [31:0] act_cnt_reg;
    logic act_ph_reg;

    wire blink_end = (blink_cnt_reg == BLINK_HALF_CYC - 32'h1);
    wire act_end = (act_cnt_reg == ACT_HALF_CYC - 32'h1);

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            blink_cnt_reg <= 32'h0;
            blink_reg <= 1'b0;
            act_cnt_reg <= 32'h0;
            act_ph_reg <= 1'b0;
        end else begin
            blink_cnt_reg <= blink_end ? 32'h0 : blink_cnt_reg + 32'h1;
            blink_reg <= blink_end ? ~blink_reg : blink_reg;
            act_cnt_reg <= act_end ? 32'h0 : act_cnt_reg + 32'h1;
            act_ph_reg <= act_end ? ~act_ph_reg : act_ph_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // network lamp

    // offline wins over any host state, so a stale run flag stays dark
    wire net_lamp_next = unit_en & s_online & (s_run | blink_reg);

    ////////////////////////////////////////////////////////////////////////////
    // module lamp

    wire mod_dark = ~unit_en | s_setup | s_netinit;
    nasi_count_t red_cnt;
    nasi_count_t flash_cnt;
    logic flash_lit;
    logic mod_green_next, mod_red_next;

    // most severe counted red pattern first
    assign red_cnt = s_intfault ? 3'h4 :
        s_noname ? 3'h3 :
        s_noip ? 3'h2 :
        s_idmis ? 3'h1 : 3'h0;

    wire red_pat = (red_cnt != 3'h0);
    wire green_diag = ~red_pat & ~s_ident & s_diag;
    assign flash_cnt = mod_dark | s_except ? 3'h0 :
        red_pat ? red_cnt :
        green_diag ? 3'h1 : 3'h0;

    nasi_flash #(.ON_CYC(FLASH_ON_CYC), .GAP_CYC(FLASH_GAP_CYC)) u_flash (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .count_i(flash_cnt),
        .lit_o(flash_lit)
    );

    always_comb begin
        mod_green_next = 1'b0;
        mod_red_next = 1'b0;
        if (mod_dark) begin
            mod_green_next = 1'b0;
        end else if (s_except) begin
            mod_red_next = 1'b1;
        end else if (red_pat) begin
            mod_red_next = flash_lit;
        end else if (s_ident) begin
            mod_green_next = blink_reg;
        end else if (s_diag) begin
            mod_green_next = flash_lit;
        end else begin
            mod_green_next = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port lamps

    logic [PORTS-1:0] act_seen_reg;
    logic [PORTS-1:0] act_show_reg;
    logic [PORTS-1:0] port_next;

    // short frames are stretched to one activity half period so they stay visible
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                act_seen_reg[p] <= 1'b0;
                act_show_reg[p] <= 1'b0;
            end else begin
                act_seen_reg[p] <= act_end ? act_s[p] : act_seen_reg[p] | act_s[p];
                act_show_reg[p] <= act_end ? act_seen_reg[p] : act_show_reg[p];
            end
        end
        assign port_next[p] = unit_en & link_s[p] & ~(act_show_reg[p] & act_ph_reg);
    end

    // ports sit just above the robot gate bit, upper bits read zero
    assign lamp_word = {{(28 - PORTS){1'b0}}, port_lamp_o, robot_enable_o,
        module_state_lamp_red_o, module_state_lamp_green_o, network_state_lamp_o};

    ////////////////////////////////////////////////////////////////////////////
    // state and outputs

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ctrl_reg <= `NASI_CTRL_RST;
            alarm_reg <= '0;
            stop_last_reg <= 1'b0;
            alarm_active_o <= 1'b0;
            alarm_group_o <= 16'h0;
            alarm_type_o <= 16'h0;
            robot_enable_o <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= {31'h0, pwdata[`NASI_CTRL_EN_BIT]};
            end
            alarm_reg <= alarm_next;
            stop_last_reg <= s_stop;
            alarm_active_o <= any_alarm;
            alarm_group_o <= any_alarm ? `NASI_ALM_GROUP : 16'h0;
            alarm_type_o <= type_sel;
            robot_enable_o <= run_ok;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            network_state_lamp_o <= 1'b0;
            module_state_lamp_green_o <= 1'b0;
            module_state_lamp_red_o <= 1'b0;
            port_lamp_o <= '0;
        end else begin
            network_state_lamp_o <= net_lamp_next;
            module_state_lamp_green_o <= mod_green_next;
            module_state_lamp_red_o <= mod_red_next;
            port_lamp_o <= port_next;
        end
    end

    // one wait state: data captured on the first access edge
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= acc_first;
            prdata <= acc_first ? rd_mux : 32'h0;
            pslverr <= acc_first & ~hit;
        end
    end
endmodule

/* File: hw/nasi_defines.svh */
`ifndef NASI_DEFINES_SVH
`define NASI_DEFINES_SVH

// system clock in kHz, used to turn times into cycle counts
`define NASI_CLK_KHZ 50000

// lamp timing in milliseconds
`define NASI_FLASH_ON_MS 200
`define NASI_FLASH_GAP_MS 1000
`define NASI_BLINK_HALF_MS 500
`define NASI_ACT_HALF_MS 50

// register byte offsets
`define NASI_OFF_CTRL 12'h000
`define NASI_OFF_ALARM 12'h004
`define NASI_OFF_CODE 12'h008
`define NASI_OFF_LAMP 12'h00c
`define NASI_OFF_COND 12'h010

// control register
`define NASI_CTRL_EN_BIT 0
`define NASI_CTRL_RST 32'h0000_0001

// alarm flag positions
`define NASI_ALM_LINK 0
`define NASI_ALM_TIMEOUT 1
`define NASI_ALM_STOP 2
`define NASI_ALM_ESTOP 3
`define NASI_ALM_NETINIT 4
`define NASI_ALM_OPTSET 5
`define NASI_ALM_SIOINIT 6
`define NASI_ALM_W 7

// alarm group and type codes
`define NASI_ALM_GROUP 16'h000c
`define NASI_TYPE_LINK 16'h023b
`define NASI_TYPE_TIMEOUT 16'h023c
`define NASI_TYPE_STOP 16'h0190
`define NASI_TYPE_ESTOP 16'h0258
`define NASI_TYPE_NETINIT 16'h02fd
`define NASI_TYPE_OPTSET 16'h0384
`define NASI_TYPE_SIOINIT 16'h0338

// lamp status register layout
`define NASI_LAMP_NET 0
`define NASI_LAMP_MSG 1
`define NASI_LAMP_MSR 2
`define NASI_LAMP_RUN 3
`define NASI_LAMP_PORT 4

`endif

/* File: hw/nasi_pkg.sv */
package nasi_pkg;

    typedef enum logic [3:0] {
        FL_IDLE = 4'b0001,
        FL_ON = 4'b0010,
        FL_OFF = 4'b0100,
        FL_GAP = 4'b1000
    } nasi_flash_t;

    typedef logic [2:0] nasi_count_t;

endpackage

/* File: hw/nasi_sync.sv */
`timescale 1ns/1ps
module nasi_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // levels in and out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second one
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                meta_reg[i] <= 1'b0;
                q_o[i] <= 1'b0;
            end else begin
                meta_reg[i] <= d_i[i];
                q_o[i] <= meta_reg[i];
            end
        end
    end
endmodule

/* File: hw/nasi_flash.sv */
`timescale 1ns/1ps
module nasi_flash #(
    parameter int unsigned ON_CYC = 10000000,
    parameter int unsigned GAP_CYC = 50000000
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // flashes per group, zero keeps the lamp dark
    input wire nasi_pkg::nasi_count_t count_i,
    output logic lit_o
);
    import nasi_pkg::*;

    nasi_flash_t state_reg, state_next;
    logic [31:0] timer_reg, timer_next;
    nasi_count_t left_reg, left_next;
    logic expired;

    assign expired = (timer_reg == 32'h0);

    // count is latched only between groups; a group is cut short only when count drops to zero
    always_comb begin
        state_next = state_reg;
        timer_next = expired ? timer_reg : timer_reg - 32'h1;
        left_next = left_reg;
        case (state_reg)
            FL_IDLE: begin
                if (count_i != 3'h0) begin
                    state_next = FL_ON;
                    timer_next = ON_CYC - 32'h1;
                    left_next = count_i;
                end
            end
            FL_ON: begin
                if (expired) begin
                    left_next = left_reg - 3'h1;
                    state_next = (left_reg == 3'h1) ? FL_GAP : FL_OFF;
                    timer_next = (left_reg == 3'h1) ? GAP_CYC - 32'h1 : ON_CYC - 32'h1;
                end
            end
            FL_OFF: begin
                if (expired) begin
                    state_next = FL_ON;
                    timer_next = ON_CYC - 32'h1;
                end
            end
            FL_GAP: begin
                if (expired) begin
                    state_next = FL_IDLE;
                end
            end
            default: begin
                state_next = FL_IDLE;
            end
        endcase
        if (count_i == 3'h0) begin
            state_next = FL_IDLE;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_reg <= FL_IDLE;
            timer_reg <= 32'h0;
            left_reg <= 3'h0;
            lit_o <= 1'b0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            left_reg <= left_next;
            lit_o <= (state_next == FL_ON);
        end
    end
endmodule

/* File: test/nasi_host_model.sv */
`timescale 1ns/1ps
module nasi_host_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // wanted state: 0 off, 1 stop, 2 run
    input wire logic [1:0] mode_i,
    // host side levels
    output logic host_online_o,
    output logic host_run_o,
    output logic host_estop_ok_o,
    output logic host_stop_ok_o,
    output logic link_err_o
);
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            {host_online_o, host_run_o, host_estop_ok_o, host_stop_ok_o, link_err_o} <= 5'h00;
        end else begin
            host_online_o <= mode_i != 2'h0;
            link_err_o <= mode_i == 2'h0;
            // run only after a cycle online, never straight from off
            host_run_o <= mode_i == 2'h2 && host_online_o;
            host_estop_ok_o <= mode_i != 2'h0;
            host_stop_ok_o <= mode_i != 2'h0;
        end
    end
endmodule

/* File: test/nasi_chk.sv */
`timescale 1ns/1ps
module nasi_chk #(
    parameter int PORTS = 2
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // conditions
    input wire logic host_online_i,
    input wire logic opt_id_bad_i,
    input wire logic estop_open_i,
    input wire logic setup_state_i,
    input wire logic net_init_state_i,
    input wire logic exception_i,
    input wire logic [PORTS-1:0] port_link_i,
    // results
    input wire logic alarm_active_o,
    input wire logic [15:0] alarm_group_o,
    input wire logic [15:0] alarm_type_o,
    input wire logic network_state_lamp_o,
    input wire logic module_state_lamp_green_o,
    input wire logic module_state_lamp_red_o,
    input wire logic [PORTS-1:0] port_lamp_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb access not answered after one wait");
    apb_err_ready_a: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    estop_alarm_a: assert property ($rose(estop_open_i) |-> ##[3:5] alarm_active_o)
        else $error("open stop source raised no alarm");
    group_code_a: assert property (alarm_active_o |-> alarm_group_o == 16'h000c)
        else $error("alarm group code wrong");
    optset_type_a: assert property ($rose(opt_id_bad_i) |-> ##[3:5] alarm_type_o == 16'h0384)
        else $error("option setting alarm type wrong");
    net_dark_a: assert property ((!host_online_i)[*6] |-> !network_state_lamp_o)
        else $error("network lamp lit while offline");
    mod_setup_dark_a: assert property ((setup_state_i || net_init_state_i)[*6] |->
        !module_state_lamp_green_o && !module_state_lamp_red_o)
        else $error("module lamp lit during setup");
    mod_exc_red_a: assert property ((exception_i && !setup_state_i
        && !net_init_state_i)[*6] |-> !module_state_lamp_green_o)
        else $error("module lamp green in exception");
    port_dark_a: assert property ((!port_link_i[0])[*6] |-> !port_lamp_o[0])
        else $error("port lamp lit without link");
endmodule

bind nasi_top nasi_chk #(.PORTS(PORTS)) u_chk (.clock_i, .srst_i, .psel, .penable, .pready,
    .pslverr, .host_online_i, .opt_id_bad_i, .estop_open_i, .setup_state_i, .net_init_state_i,
    .exception_i, .port_link_i, .alarm_active_o, .alarm_group_o, .alarm_type_o,
    .network_state_lamp_o, .module_state_lamp_green_o, .module_state_lamp_red_o, .port_lamp_o);

/* File: test/nasi_top_tb.sv */
`timescale 1ns/1ps
module nasi_top_tb;
    localparam int BH = 8;
    localparam int W = 96;
    logic clock_i;
    logic srst_i;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire ho, hr, he, hs, hl, act, renb, nl, msg, msr;
    wire [15:0] grp, typ;
    wire [1:0] pl;
    wire [4:0] lamps = {pl, msr, msg, nl};
    logic [23:0] c;
    logic [1:0] mode;
    int fails, n_checks, cyc, hi, ri, mg;
    logic [31:0] q;
    logic e;
    // condition pins, expected type code
    logic [39:0] arow [10] = '{{24'h000002, 16'h023b}, {24'h000001, 16'h023c},
        {24'h000180, 16'h0190}, {24'h000280, 16'h0190}, {24'h000400, 16'h0258},
        {24'h000004, 16'h02fd}, {24'h000010, 16'h0384}, {24'h000020, 16'h0384},
        {24'h000040, 16'h0384}, {24'h000008, 16'h0338}};
    // condition pins, measure (0 lit, 1 rises, 2 flashes per group), lamp, expected
    logic [36:0] lrow [14] = '{{24'h0, 2'd0, 3'd0, 8'(W)}, {24'h0, 2'd0, 3'd1, 8'(W)},
        {24'h000800, 2'd0, 3'd1, 8'd0}, {24'h001000, 2'd0, 3'd1, 8'd0},
        {24'h002000, 2'd0, 3'd2, 8'(W)}, {24'h004000, 2'd2, 3'd1, 8'd1},
        {24'h008000, 2'd1, 3'd1, 8'(W / (2 * BH))}, {24'h010000, 2'd2, 3'd2, 8'd1},
        {24'h020000, 2'd2, 3'd2, 8'd2}, {24'h040000, 2'd2, 3'd2, 8'd3},
        {24'h080000, 2'd2, 3'd2, 8'd4}, {24'h0a0000, 2'd2, 3'd2, 8'd4},
        {24'h060000, 2'd2, 3'd2, 8'd3}, {24'h100000, 2'd0, 3'd3, 8'(W)}};

    nasi_host_model u_host (.clock_i(clock_i), .srst_i(srst_i), .mode_i(mode),
        .host_online_o(ho), .host_run_o(hr), .host_estop_ok_o(he), .host_stop_ok_o(hs),
        .link_err_o(hl));

    nasi_top #(.FLASH_ON_CYC(4), .FLASH_GAP_CYC(12), .BLINK_HALF_CYC(BH),
        .ACT_HALF_CYC(4)) DUT (.clock_i(clock_i), .srst_i(srst_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_err_i(c[1] | hl), .cyc_timeout_i(c[0]),
        .host_online_i(ho), .host_run_i(hr), .net_init_fail_i(c[2]), .sio_init_fail_i(c[3]),
        .opt_id_bad_i(c[4]), .opt_mix_bad_i(c[5]), .opt_unknown_i(c[6]),
        .stop_active_i(c[7]), .motion_req_i(c[8]), .motion_busy_i(c[9]),
        .estop_open_i(c[10]), .host_estop_ok_i(he), .host_stop_ok_i(hs),
        .setup_state_i(c[11]), .net_init_state_i(c[12]), .exception_i(c[13]),
        .diag_event_i(c[14]), .identify_req_i(c[15]), .id_mismatch_i(c[16]),
        .no_ip_i(c[17]), .no_name_i(c[18]), .internal_fault_i(c[19]),
        .port_link_i(c[21:20]), .port_act_i(c[23:22]), .alarm_active_o(act),
        .alarm_group_o(grp), .alarm_type_o(typ), .robot_enable_o(renb),
        .network_state_lamp_o(nl), .module_state_lamp_green_o(msg),
        .module_state_lamp_red_o(msr), .port_lamp_o(pl));

    ////////////////////////////////////////////////////////////////
    task automatic wait_c(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    // one edge first so a strobe is never dropped and raised in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do @(posedge clock_i); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_checks++;
        if (g !== x) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask

    // low runs longer than 8 cycles, twice the flash spacing, end a flash group
    task automatic watch(input int s);
        int g;
        int lo;
        logic p;
        hi = 0;
        ri = 0;
        mg = 0;
        g = 0;
        lo = 0;
        p = lamps[s];
        repeat (W) begin
            @(posedge clock_i);
            if (lamps[s] === 1'b1) begin
                hi++;
                lo = 0;
                ri += (p !== 1'b1);
                g += (p !== 1'b1);
            end else begin
                lo++;
                g = (lo > 8) ? 0 : g;
            end
            mg = (g > mg) ? g : mg;
            p = lamps[s];
        end
    endtask

    task summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 10000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        {srst_i, psel, penable, pwrite, paddr, pwdata, c, mode} = {4'h8, 68'h0, 2'h2};
        wait_c(3);
        srst_i <= 1'b0;
        foreach (arow[i]) begin
            c <= 24'h0;
            wait_c(8);
            apb(1'b1, 12'h004, 32'h7f);
            apb(1'b0, 12'h008, 32'h0);
            chk("code cleared", 32'h0, q);
            // stop is raised last so busy or request is already there
            c <= arow[i][39:16] & ~24'h80;
            wait_c(5);
            c <= arow[i][39:16];
            wait_c(8);
            apb(1'b0, 12'h008, 32'h0);
            chk("code", {16'h000c, arow[i][15:0]}, q);
            chk("type pins", {16'h0, arow[i][15:0]}, {16'h0, typ});
            chk("group pins", 32'h000c, {16'h0, grp});
        end
        foreach (lrow[i]) begin
            c <= lrow[i][36:13];
            wait_c(60);
            watch(int'(lrow[i][10:8]));
            q = (lrow[i][12:11] == 2'd0) ? hi : (lrow[i][12:11] == 2'd1) ? ri : mg;
            chk("lamp pattern", {24'h0, lrow[i][7:0]}, q);
        end
        c <= 24'h700000;
        wait_c(60);
        watch(3);
        chk("port activity", 32'h1, {31'h0, ri > 0 && hi < W});
        watch(4);
        chk("port link steady", W, hi);
        mode <= 2'h1;
        wait_c(60);
        watch(0);
        chk("network stop blink", W / (2 * BH), ri);
        mode <= 2'h0;
        wait_c(60);
        watch(0);
        chk("network offline", 32'h0, hi);
        chk("robot blocked", 32'h0, {31'h0, renb});
        apb(1'b1, 12'h000, 32'h0);
        wait_c(4);
        chk("robot free when disabled", 32'h1, {31'h0, renb});
        // disabled unit: every lamp dark, only the robot gate bit set
        apb(1'b0, 12'h00c, 32'h0);
        chk("lamp word", 32'h8, q);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, q);
        srst_i <= 1'b1;
        wait_c(3);
        srst_i <= 1'b0;
        chk("alarm after reset", 32'h0, {31'h0, act});
        apb(1'b0, 12'h000, 32'h0);
        chk("control reset", 32'h1, q);
        summarize();
    end
endmodule
